// ===== verilog/serial_channel_start_stop_irq.sv
/*
 Start/stop trigger and interrupt request/mask bank for a two-channel
 clocked-serial master, reached over APB.
 Assumes the shift datapath reports busy, transfer end and buffer empty
 per channel, synchronous to core_clk.
*/
// How it works
// RULE1 - start bit 1 enables channel, waits
// RULE2 - stop bit 1 clears channel enable
// RULE3 - request flag bit 3 shows pending
// RULE4 - mask bit 3 blocks servicing when 1
// RULE5 - software starts, clears flag, clears mask
// RULE6 - software stops, clears flag, sets mask
// RULE7 - rate setting stays 200 to 2000 kbps
// RULE8 - source select: end or buffer empty
// RULE9 - status bit 6 shows transfer running
// RULE10 - event sets flag regardless of mask
`timescale 1ns/1ps
`include "serial_start_stop_defines.svh"

module serial_channel_start_stop_irq
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] xferBusy,
   input wire logic [1:0] xferEnd,
   input wire logic [1:0] bufEmpty,
   output logic [1:0] channelEnable,
   output logic irq
);
   import serial_start_stop_pkg::*;

   // Bank state and its next value
   bank_state_s state_q;
   bank_state_s state_d;
   // Per-channel views from the cells
   logic [1:0] chanEnable;
   logic [1:0] chanBusy;
   logic [1:0] chanEvent;
   // Bus decode helpers
   logic accessPhase;
   logic writeNow;
   logic serialEvent;

   // ----------------------------------------------------------------
   // Channel cells
   // ----------------------------------------------------------------
   // Trigger pulses come from bank flops, so each lasts one cycle
   // Cells see datapath levels and pulses of their own channel only
   generate
      for (genvar ch = 0; ch < `NUM_CHANNELS; ch++)
      begin : g_chan
         serial_channel_cell u_cell
         (
            .core_clk(core_clk),
            .rstn(rstn),
            .startPulse(state_q.startPulse[ch]),
            .stopPulse(state_q.stopPulse[ch]),
            .srcSelect(state_q.srcSelect[ch]),
            .xferBusy(xferBusy[ch]),
            .xferEnd(xferEnd[ch]),
            .bufEmpty(bufEmpty[ch]),
            .channelEnable(chanEnable[ch]),
            .transferInProgress(chanBusy[ch]),
            .irqEvent(chanEvent[ch])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Bus phase decode
   // ----------------------------------------------------------------
   // Access waits one cycle, write lands on the pready edge
   // Read data latched in first access cycle, stands with pready
   assign accessPhase = psel && penable && !state_q.pready;
   assign writeNow = psel && penable && pwrite && state_q.pready;
   // Other channel still lands in event status only
   // Event of the channel routed to the serial request flag
   assign serialEvent = chanEvent[state_q.channelSel];

   // ----------------------------------------------------------------
   // Next state of the register bank
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      state_d.pready = accessPhase;
      state_d.pslverr = 1'b0;
      state_d.startPulse = 2'b00;
      state_d.stopPulse = 2'b00;
      // Read data and error prepared during the wait cycle
      if (accessPhase)
      begin
         state_d.prdata = 32'h0000_0000;
         if (paddr == `OFS_START_TRIGGER || paddr == `OFS_STOP_TRIGGER || paddr == `OFS_EVT_CLEAR)
         begin
            state_d.prdata = 32'h0000_0000;
         end
         else if (paddr == `OFS_IRQ_REQUEST)
         begin
            // RULE3 flag readback
            state_d.prdata[`BIT_SERIAL_IRQ] = state_q.irqRequest;
         end
         else if (paddr == `OFS_IRQ_MASK)
         begin
            state_d.prdata[`BIT_SERIAL_IRQ] = state_q.irqMask;
         end
         else if (paddr == `OFS_CHANNEL_MODE)
         begin
            state_d.prdata[`BIT_SRC_SEL_CH0] = state_q.srcSelect[0];
            state_d.prdata[`BIT_SRC_SEL_CH1] = state_q.srcSelect[1];
            state_d.prdata[`BIT_CHANNEL_SEL] = state_q.channelSel;
         end
         else if (paddr == `OFS_CH0_STATUS)
         begin
            state_d.prdata[`BIT_CH_ENABLE] = chanEnable[0];
            // RULE9 busy readback
            state_d.prdata[`BIT_CH_BUSY] = chanBusy[0];
         end
         else if (paddr == `OFS_CH1_STATUS)
         begin
            state_d.prdata[`BIT_CH_ENABLE] = chanEnable[1];
            state_d.prdata[`BIT_CH_BUSY] = chanBusy[1];
         end
         else if (paddr == `OFS_EVT_STATUS)
         begin
            state_d.prdata[3:0] = state_q.evtStatus;
         end
         else if (paddr == `OFS_EVT_ENABLE)
         begin
            state_d.prdata[3:0] = state_q.evtEnable;
         end
         else
         begin
            state_d.pslverr = 1'b1;
         end
      end
      // Trigger bits become one-cycle pulses; zero bits do nothing
      // Register writes
      if (writeNow)
      begin
         if (paddr == `OFS_START_TRIGGER)
         begin
            // RULE1 ones trigger, zeros ignored
            state_d.startPulse = pwdata[1:0];
         end
         else if (paddr == `OFS_STOP_TRIGGER)
         begin
            // RULE2 ones trigger, zeros ignored
            state_d.stopPulse = pwdata[1:0];
         end
         else if (paddr == `OFS_IRQ_REQUEST)
         begin
            state_d.irqRequest = pwdata[`BIT_SERIAL_IRQ];
         end
         else if (paddr == `OFS_IRQ_MASK)
         begin
            state_d.irqMask = pwdata[`BIT_SERIAL_IRQ];
         end
         else if (paddr == `OFS_CHANNEL_MODE)
         begin
            state_d.srcSelect[0] = pwdata[`BIT_SRC_SEL_CH0];
            state_d.srcSelect[1] = pwdata[`BIT_SRC_SEL_CH1];
            state_d.channelSel = pwdata[`BIT_CHANNEL_SEL];
         end
         else if (paddr == `OFS_EVT_CLEAR)
         begin
            state_d.evtStatus = state_q.evtStatus & ~pwdata[3:0];
         end
         else if (paddr == `OFS_EVT_ENABLE)
         begin
            state_d.evtEnable = pwdata[3:0];
         end
      end
      // RULE10 event sets flag, mask ignored
      if (serialEvent)
      begin
         state_d.irqRequest = 1'b1;
      end
      // Sticky events win over a clear in the same cycle
      state_d.evtStatus = state_d.evtStatus | {state_q.stopPulse != 2'b00, state_q.startPulse != 2'b00, chanEvent};
      // Registered, so irq trails the flags by one cycle
      // RULE4 mask gates servicing
      state_d.irq = (state_q.irqRequest && !state_q.irqMask) || ((state_q.evtStatus & state_q.evtEnable) != 4'h0);
      // Enable output trails the cell flag by one cycle
      state_d.enableOut = chanEnable;
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   // Reset values of the bank; mask comes up set
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= '{irqRequest: `RST_IRQ_REQUEST, irqMask: `RST_IRQ_MASK, srcSelect: 2'h0, channelSel: 1'b0,
                      evtStatus: `RST_EVT, evtEnable: `RST_EVT, prdata: 32'h0000_0000, pready: 1'b0,
                      pslverr: 1'b0, irq: 1'b0, startPulse: 2'h0, stopPulse: 2'h0, enableOut: 2'h0};
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Outputs straight from flops
   assign prdata = state_q.prdata;
   assign pready = state_q.pready;
   assign pslverr = state_q.pslverr;
   assign irq = state_q.irq;
   assign channelEnable = state_q.enableOut;

endmodule

// ===== verilog/serial_start_stop_defines.svh
/*
 Register offsets, field positions and reset values of the serial channel
 start/stop and interrupt control block.
 Assumes byte addressing on an APB bus with 32-bit data words.
*/
`ifndef SERIAL_START_STOP_DEFINES_SVH
`define SERIAL_START_STOP_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_START_TRIGGER 8'h00
`define OFS_STOP_TRIGGER 8'h04
`define OFS_IRQ_REQUEST 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_CHANNEL_MODE 8'h10
`define OFS_CH0_STATUS 8'h18
`define OFS_CH1_STATUS 8'h1C
`define OFS_EVT_STATUS 8'h20
`define OFS_EVT_CLEAR 8'h24
`define OFS_EVT_ENABLE 8'h28

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_SERIAL_IRQ 3
`define BIT_SRC_SEL_CH0 0
`define BIT_SRC_SEL_CH1 1
`define BIT_CHANNEL_SEL 4
`define BIT_CH_ENABLE 0
`define BIT_CH_BUSY 6
`define NUM_CHANNELS 2
`define NUM_EVENTS 4
`define EVT_CH0_IRQ 0
`define EVT_CH1_IRQ 1
`define EVT_START 2
`define EVT_STOP 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_IRQ_REQUEST 1'b0
`define RST_IRQ_MASK 1'b1
`define RST_MODE 3'h0
`define RST_EVT 4'h0

`endif

// ===== verilog/serial_start_stop_pkg.sv
/*
 Types shared by the serial channel start/stop block and its channel cell.
 Assumes the defines header is included first.
*/
package serial_start_stop_pkg;

   // ----------------------------------------------------------------
   // Register bank state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic irqRequest;
      logic irqMask;
      logic [1:0] srcSelect;
      logic channelSel;
      logic [3:0] evtStatus;
      logic [3:0] evtEnable;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic [1:0] startPulse;
      logic [1:0] stopPulse;
      logic [1:0] enableOut;
   } bank_state_s;

   // ----------------------------------------------------------------
   // Channel state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CH_STOPPED,
      CH_WAIT,
      CH_RUNNING
   } chan_mode_e;

   typedef struct packed {
      chan_mode_e mode;
   } chan_state_s;

endpackage

// ===== verilog/serial_channel_cell.sv
/*
 One serial channel: enable flag, communication wait/run state and the
 selected interrupt event.
 Assumes trigger pulses last one cycle and datapath inputs are synchronous.
*/
`timescale 1ns/1ps
`include "serial_start_stop_defines.svh"

module serial_channel_cell
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic startPulse,
   input wire logic stopPulse,
   input wire logic srcSelect,
   input wire logic xferBusy,
   input wire logic xferEnd,
   input wire logic bufEmpty,
   output logic channelEnable,
   output logic transferInProgress,
   output logic irqEvent
);
   import serial_start_stop_pkg::*;

   chan_state_s state_q;
   chan_state_s state_d;

   // Next channel state; stop wins over a start in the same cycle
   always_comb
   begin
      state_d = state_q;
      case (state_q.mode)
         CH_STOPPED:
         begin
            // RULE1 start sets enable
            if (startPulse && !stopPulse)
            begin
               state_d.mode = CH_WAIT;
            end
         end
         CH_WAIT:
         begin
            if (stopPulse)
            begin
               state_d.mode = CH_STOPPED;
            end
            else if (xferBusy)
            begin
               state_d.mode = CH_RUNNING;
            end
         end
         CH_RUNNING:
         begin
            // RULE2 stop clears enable
            if (stopPulse)
            begin
               state_d.mode = CH_STOPPED;
            end
            else if (!xferBusy)
            begin
               state_d.mode = CH_WAIT;
            end
         end
         default:
         begin
            state_d.mode = CH_STOPPED;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= '{mode: CH_STOPPED};
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Status views
   assign channelEnable = (state_q.mode != CH_STOPPED);
   // RULE9 busy only while running
   assign transferInProgress = (state_q.mode == CH_RUNNING);
   // RULE8 source select picks event
   assign irqEvent = channelEnable && (srcSelect ? bufEmpty : xferEnd);

endmodule

// ===== dv/serial_start_stop_monitor.sv
/*
 Port checker for the start/stop and interrupt bank.
 Assumes one clock domain, APB answer after one wait state.
*/
`timescale 1ns/1ps

module serial_start_stop_monitor
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] channelEnable,
   input wire logic irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   // Answer timing and error response
   property p_rdyOne; pready |=> !pready; endproperty
   property p_rdyWait; psel && !penable ##1 psel && penable |=> pready; endproperty
   property p_errAddr;
      pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28});
   endproperty
   // Trigger effects on channel 1; a zero start write must leave both channels stable
   property p_start; pready && pwrite && paddr == 8'h00 && pwdata[1] |-> ##[1:3] channelEnable[1]; endproperty
   property p_stop; pready && pwrite && paddr == 8'h04 && pwdata[1] |-> ##[1:3] !channelEnable[1]; endproperty
   property p_noAct;
      pready && pwrite && paddr == 8'h00 && pwdata[1:0] == 2'h0 |-> ##1 $stable(channelEnable)[*3];
   endproperty
   // Read data layout
   property p_reqBits; pready && !pwrite && paddr == 8'h08 |-> (prdata & ~32'h8) == 32'h0; endproperty
   property p_status; pready && !pwrite && paddr == 8'h1C |-> prdata[0] == channelEnable[1]; endproperty
   property p_wo; pready && !pwrite && paddr inside {8'h00, 8'h04, 8'h24} |-> prdata == 32'h0; endproperty

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_rdyOne: assert property (p_rdyOne) else $error("pready longer than one cycle");
   a_rdyWait: assert property (p_rdyWait) else $error("pready not after one wait state");
   a_errAddr: assert property (p_errAddr) else $error("pslverr wrong for address");
   a_start: assert property (p_start) else $error("start did not enable channel");
   a_stop: assert property (p_stop) else $error("stop did not disable channel");
   a_noAct: assert property (p_noAct) else $error("zero start write changed enable");
   a_reqBits: assert property (p_reqBits) else $error("request register stray bits");
   a_status: assert property (p_status) else $error("status enable mismatch");
   a_wo: assert property (p_wo) else $error("write-only register read non-zero");

   c_start: cover property (p_start);
   c_err: cover property (pready && pslverr);
   c_irq: cover property ($rose(irq));
endmodule

// ===== dv/serial_datapath_model.sv
/*
 Stand-in for the shift datapath on both channels.
 Assumes the bench asks for events one cycle at a time.
*/
`timescale 1ns/1ps

module serial_datapath_model
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [1:0] runReq,
   input wire logic [1:0] endReq,
   input wire logic [1:0] emptyReq,
   input wire logic [1:0] channelEnable,
   output logic [1:0] xferBusy,
   output logic [1:0] xferEnd,
   output logic [1:0] bufEmpty
);
   // Busy only on an enabled channel; events pass as one-cycle pulses
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         xferBusy <= 2'h0;
         xferEnd <= 2'h0;
         bufEmpty <= 2'h0;
      end
      else
      begin
         xferBusy <= runReq & channelEnable;
         xferEnd <= endReq;
         bufEmpty <= emptyReq;
      end
   end
endmodule

// ===== dv/serial_channel_start_stop_irq_test.sv
/*
 Self-checking bench for the start/stop and interrupt bank.
 Assumes the datapath model and checker beside it.
*/
`timescale 1ns/1ps

module serial_channel_start_stop_irq_test;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq;
   logic [1:0] xferBusy, xferEnd, bufEmpty, channelEnable;
   logic [1:0] runReq = 2'h0;
   logic [1:0] endReq = 2'h0;
   logic [1:0] emptyReq = 2'h0;
   int fails = 0;
   int checks_done = 0;

   always #4 core_clk = ~core_clk;

   serial_channel_start_stop_irq dut_u (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .xferBusy(xferBusy), .xferEnd(xferEnd), .bufEmpty(bufEmpty), .channelEnable(channelEnable), .irq(irq));
   serial_datapath_model dp_u (.core_clk(core_clk), .rstn(rstn), .runReq(runReq), .endReq(endReq),
      .emptyReq(emptyReq), .channelEnable(channelEnable), .xferBusy(xferBusy), .xferEnd(xferEnd),
      .bufEmpty(bufEmpty));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task wrap_up();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer, waits for pready under a bound
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      // Look between edges, so pready is settled before the edge that takes it
      @(negedge core_clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(negedge core_clk);
         n++;
      end
      if (pready !== 1'b1)
      begin
         fails++;
         wrap_up();
      end
      r = prdata;
      e = pslverr;
      @(posedge core_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      repeat (3) @(posedge core_clk);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
      chk({31'h0, e}, {31'h0, !(a inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28})});
   endtask

   // event spacing stands for an in-range rate
   task pulse(input logic [1:0] en, input logic [1:0] em);
      endReq <= en;
      emptyReq <= em;
      @(posedge core_clk);
      endReq <= 2'h0;
      emptyReq <= 2'h0;
      repeat (4) @(posedge core_clk);
   endtask

   task outs(input logic [1:0] en, input logic q);
      chk({30'h0, channelEnable}, {30'h0, en});
      chk({31'h0, irq}, {31'h0, q});
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset();
      rd(8'h08, 32'h0);
      rd(8'h0C, 32'h8);
      rd(8'h00, 32'h0);
      rd(8'h14, 32'h0);
      outs(2'h0, 1'b0);
   endtask

   task t_start();
      wr(8'h00, 32'h2);
      outs(2'h2, 1'b0);
      wr(8'h00, 32'h0);
      outs(2'h2, 1'b0);
   endtask

   task t_irq();
      wr(8'h10, 32'h10);
      pulse(2'h2, 2'h0);
      rd(8'h08, 32'h8);
      outs(2'h2, 1'b0);
      wr(8'h08, 32'h0);
      wr(8'h0C, 32'h0);
      outs(2'h2, 1'b0);
      pulse(2'h2, 2'h0);
      outs(2'h2, 1'b1);
      runReq <= 2'h2;
      repeat (3) @(posedge core_clk);
      rd(8'h1C, 32'h41);
      runReq <= 2'h0;
      wr(8'h08, 32'h0);
      outs(2'h2, 1'b0);
      wr(8'h10, 32'h12);
      pulse(2'h2, 2'h0);
      rd(8'h08, 32'h0);
      pulse(2'h0, 2'h2);
      rd(8'h08, 32'h8);
   endtask

   task t_stop();
      wr(8'h04, 32'h2);
      wr(8'h08, 32'h0);
      wr(8'h0C, 32'h8);
      outs(2'h0, 1'b0);
      rd(8'h1C, 32'h0);
      pulse(2'h0, 2'h2);
      rd(8'h08, 32'h0);
   endtask

   task t_evt();
      rd(8'h20, 32'hE);
      wr(8'h24, 32'hF);
      rd(8'h20, 32'h0);
      wr(8'h28, 32'h4);
      wr(8'h00, 32'h1);
      outs(2'h1, 1'b1);
      wr(8'h24, 32'h4);
      outs(2'h1, 1'b0);
   endtask

   // Main sequence
   initial
   begin
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_start();
      t_irq();
      t_stop();
      t_evt();
      wrap_up();
   end
endmodule

bind serial_channel_start_stop_irq serial_start_stop_monitor mon_u (.core_clk(core_clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .channelEnable(channelEnable), .irq(irq));
